//--- tb/drive_amp_model.sv
// Drive amplifier model counting step pulses
`timescale 1ns/1ps
module drive_amp_model
   import vspeed_pkg::*;
(
   input wire logic clock,
   input wire vspeed_pkg::drive_s drive,
   input wire logic [1:0] sel,
   output int edges,
   output logic dir
);
   logic last;
   int count = 0;
   assign edges = count;
   always @(posedge clock) begin
      last <= drive.pulse[sel];
      if (drive.pulse[sel] && !last) begin
         count <= count + 1;
         dir <= drive.direction[sel];
      end
   end
endmodule

//--- tb/variable_speed_pulse_output_test.sv
// Self-checking bench for the pulse output block
`timescale 1ns/1ps
module variable_speed_pulse_output_test;
   import vspeed_pkg::*;
   logic clock, nrst, scan, accel, edit, exec, dir;
   command_s command;
   drive_s drive;
   logic [3:0] busy;
   logic [15:0] step_hz;
   int fail_count, checked, cyc, edges, e0;
   variable_speed_pulse_output dut_u (.clock(clock), .nrst(nrst), .command(command),
      .scan_strobe(scan), .accel_decel_enable_flag(accel), .online_edit(edit),
      .accel_step_hz(step_hz), .decel_step_hz(step_hz), .drive(drive),
      .pulse_busy_monitor_ch0(), .pulse_busy_monitor_ch1(), .busy_monitor(busy),
      .execution_state(exec));
   drive_amp_model amp_u (.clock(clock), .drive(drive), .sel(command.pulse_output_select),
      .edges(edges), .dir(dir));
   task final_report();
      $display("checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
      end
   endtask
   task settle(input int n);
      repeat (n) @(negedge clock);
   endtask
   task cmd(input logic en, input logic [31:0] f, input logic [1:0] ch);
      @(negedge clock);
      command <= '{en, 1'b1, f, ch};
   endtask
   initial begin
      clock = 0;
      forever #2.5 clock = ~clock;
   end
   // Scan end every 100 cycles, plus hang guard
   always @(negedge clock) begin
      cyc <= cyc + 1;
      scan <= (cyc % 100 == 99);
      if (cyc == 60000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      nrst = 0; accel = 0; edit = 0; step_hz = 16'h07D0; command = '0;
      settle(4);
      nrst = 1;
      cmd(1, 32'h0003_0D40, 2'h1);
      settle(5);
      chk("busy", 32'h2, busy);
      e0 = edges;
      settle(5000);
      chk("pulses", 1, (edges - e0) inside {[4:6]});
      chk("direction", 1, dir);
      cmd(1, 32'h0, 2'h1);
      settle(3);
      chk("zero stop", 0, busy);
      cmd(1, 32'hFFFC_F2C0, 2'h1);
      settle(300);
      chk("held", 0, busy);
      cmd(1, 32'h0, 2'h1);
      settle(250);
      cmd(1, 32'hFFFC_F2C0, 2'h1);
      settle(3000);
      chk("restart", 32'h2, busy);
      chk("reverse", 0, dir);
      cmd(0, 32'h0, 2'h1);
      settle(200);
      cmd(1, 32'h0003_0D40, 2'h2);
      settle(50);
      edit <= 1;
      settle(5);
      chk("edit stop", 0, busy);
      cmd(0, 32'h0, 2'h2);
      settle(200);
      edit <= 0;
      @(negedge clock);
      command <= '{1'b1, 1'b0, 32'h0000_FC18, 2'h2};
      settle(10);
      chk("narrow busy", 32'h4, busy);
      chk("narrow dir", 0, drive.direction[2]);
      cmd(0, 32'h0, 2'h2);
      settle(200);
      accel <= 1;
      cmd(1, 32'h0003_0D40, 2'h0);
      e0 = edges;
      settle(10000);
      chk("ramp pulses", 1, (edges - e0) inside {[1:5]});
      edit <= 1;
      settle(20);
      chk("slowing", 32'h1, busy);
      for (int i = 0; i < 15000 && busy !== 4'h0; i++) @(negedge clock);
      chk("halted", 0, busy);
      final_report();
   end
endmodule

//--- tb/vspeed_properties.sv
// Port checker for the pulse output block
`timescale 1ns/1ps
module vspeed_properties
   import vspeed_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire vspeed_pkg::command_s command,
   input wire logic accel_decel_enable_flag,
   input wire logic online_edit,
   input wire vspeed_pkg::drive_s drive,
   input wire logic pulse_busy_monitor_ch0,
   input wire logic pulse_busy_monitor_ch1,
   input wire logic [3:0] busy_monitor,
   input wire logic execution_state
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   a_pulse_one_pin: assert property ($onehot0(drive.pulse))
      else $error("more than one pulse pin active");
   a_busy_mirror: assert property (pulse_busy_monitor_ch0 == busy_monitor[0]
      && pulse_busy_monitor_ch1 == busy_monitor[1])
      else $error("busy flags disagree");
   a_one_channel: assert property ($onehot0(busy_monitor))
      else $error("two channels busy");
   a_run_busy: assert property (execution_state |-> |busy_monitor)
      else $error("running while not busy");
   a_edit_stop: assert property (online_edit && !accel_decel_enable_flag && execution_state
      |-> ##[1:3] !execution_state)
      else $error("edit did not stop output");
   a_zero_stop: assert property (execution_state && command.enable && command.freq == 32'h0
      && !accel_decel_enable_flag |-> ##[1:2] busy_monitor == 4'h0)
      else $error("zero rate did not stop output");
   a_dir_sign: assert property ((execution_state && command.freq != 32'h0
      && !accel_decel_enable_flag && $stable(command.freq))[*4]
      |-> (drive.direction != 4'h0) == !(command.wide ? command.freq[31] : command.freq[15]))
      else $error("direction does not follow sign");
   a_held_stop: assert property (execution_state && command.freq == 32'h0 && command.enable
      ##1 (command.enable && command.freq != 32'h0)[*3] |-> busy_monitor == 4'h0)
      else $error("restart inside held stop");
endmodule
bind variable_speed_pulse_output vspeed_properties chk_u (.clock(clock), .nrst(nrst),
   .command(command), .accel_decel_enable_flag(accel_decel_enable_flag),
   .online_edit(online_edit), .drive(drive), .pulse_busy_monitor_ch0(pulse_busy_monitor_ch0),
   .pulse_busy_monitor_ch1(pulse_busy_monitor_ch1), .busy_monitor(busy_monitor),
   .execution_state(execution_state));

//--- verilog/variable_speed_pulse_output.sv
// Variable speed pulse train generator with rotating-direction output
`timescale 1ns/1ps
module variable_speed_pulse_output
   import vspeed_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire vspeed_pkg::command_s command,
   input wire logic scan_strobe,
   input wire logic accel_decel_enable_flag,
   input wire logic online_edit,
   input wire logic [15:0] accel_step_hz,
   input wire logic [15:0] decel_step_hz,
   output vspeed_pkg::drive_s drive,
   output logic pulse_busy_monitor_ch0,
   output logic pulse_busy_monitor_ch1,
   output logic [3:0] busy_monitor,
   output logic execution_state
);
   import vspeed_pkg::*;

   logic signed [31:0] set_freq;
   logic [31:0] set_mag;
   logic set_dir;

   run_state_e state_ff, nxt_state;
   logic [31:0] rate_ff, nxt_rate;
   logic dir_ff, nxt_dir;
   logic [1:0] sel_ff, nxt_sel;
   logic zero_scan_ff, nxt_zero_scan;

   logic [15:0] tick_ff, nxt_tick;

   logic [PHASE_W-1:0] phase_ff, nxt_phase;
   logic pulse_ff, nxt_pulse;
   drive_s drive_ff, nxt_drive;
   logic ramp_tick;
   logic [31:0] target;

   // Narrow words are sign-extended so both widths share one datapath
   assign set_freq = command.wide ? $signed(command.freq)
                                  : 32'($signed(command.freq[15:0]));
   assign set_mag = set_freq[31] ? 32'(-set_freq) : 32'(set_freq);
   assign set_dir = ~set_freq[31];
   assign ramp_tick = (tick_ff == RAMP_TICK_LAST);

   always_comb begin
      nxt_state = state_ff;
      nxt_dir = dir_ff;
      nxt_sel = sel_ff;
      nxt_zero_scan = zero_scan_ff;
      target = set_mag;
      case (state_ff)
         ST_IDLE: begin
            if (command.enable && set_mag != MAG_ZERO) begin
               nxt_state = ST_RUN;
               // Channel latched so a select change mid run cannot move pins
               nxt_sel = command.pulse_output_select;
            end
         end

         ST_RUN: begin
            if (set_mag != MAG_ZERO) begin
               nxt_dir = set_dir;
            end
            if (!command.enable) begin
               nxt_state = accel_decel_enable_flag ? ST_HALT : ST_IDLE;
            end else if (online_edit) begin
               // Held, so a still-set command cannot restart during the edit
               nxt_state = accel_decel_enable_flag ? ST_HALT : ST_HELD;
               nxt_zero_scan = 1'b0;
            end else if (set_mag == MAG_ZERO) begin
               nxt_state = ST_HELD;
               nxt_zero_scan = 1'b0;
            end
         end

         ST_HALT: begin
            target = MAG_ZERO;
            if (rate_ff == MAG_ZERO) begin
               nxt_state = command.enable ? ST_HELD : ST_IDLE;
               nxt_zero_scan = 1'b0;
            end
         end

         ST_HELD: begin
            // stop held until zero spans a scan or enable drops
            if (!command.enable) begin
               nxt_state = ST_IDLE;
            end else if (set_mag != MAG_ZERO) begin
               nxt_zero_scan = 1'b0;
            end else if (scan_strobe) begin
               if (zero_scan_ff) begin
                  nxt_state = ST_IDLE;
               end
               nxt_zero_scan = 1'b1;
            end
         end

         default: nxt_state = ST_IDLE;
      endcase
   end

   always_comb begin
      nxt_rate = rate_ff;
      if (state_ff == ST_IDLE || state_ff == ST_HELD) begin
         nxt_rate = MAG_ZERO;
      end else if (!accel_decel_enable_flag) begin
         nxt_rate = (state_ff == ST_HALT) ? MAG_ZERO : target;
      end else if (ramp_tick) begin
         if (rate_ff < target) begin
            nxt_rate = (target - rate_ff > 32'(accel_step_hz)) ?
                       rate_ff + 32'(accel_step_hz) : target;
         end else if (rate_ff > target) begin
            nxt_rate = (rate_ff - target > 32'(decel_step_hz)) ?
                       rate_ff - 32'(decel_step_hz) : target;
         end
      end
      // Clamp keeps the accumulator step inside its width
      if (nxt_rate > MAX_WIDE_HZ) begin
         nxt_rate = MAX_WIDE_HZ;
      end
   end

   // phase accumulator; top bit gives one rising edge per period
   always_comb begin
      nxt_phase = phase_ff + PHASE_W'((64'(rate_ff) << PHASE_SCALE_SHIFT) / 64'(CLOCK_HZ));
      nxt_pulse = phase_ff[PHASE_W-1];
      if (rate_ff == MAG_ZERO) begin
         nxt_phase = '0;
         nxt_pulse = 1'b0;
      end
      nxt_drive.pulse = '0;
      nxt_drive.direction = '0;
      nxt_drive.pulse[sel_ff] = pulse_ff;
      nxt_drive.direction[sel_ff] = dir_ff;
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_ff <= ST_IDLE;
         dir_ff <= 1'b0;
         sel_ff <= 2'b00;
         zero_scan_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         dir_ff <= nxt_dir;
         sel_ff <= nxt_sel;
         zero_scan_ff <= nxt_zero_scan;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         rate_ff <= MAG_ZERO;
      end else begin
         rate_ff <= nxt_rate;
      end
   end

   // Ramp tick divider runs free; a ramp may start mid tick
   always_comb begin
      nxt_tick = ramp_tick ? 16'h0000 : tick_ff + 16'h0001;
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         tick_ff <= 16'h0000;
      end else begin
         tick_ff <= nxt_tick;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         phase_ff <= '0;
         pulse_ff <= 1'b0;
         drive_ff <= '0;
      end else begin
         phase_ff <= nxt_phase;
         pulse_ff <= nxt_pulse;
         drive_ff <= nxt_drive;
      end
   end

   // busy while running or slowing down
   for (genvar ch = 0; ch < 4; ch++) begin : g_busy
      assign busy_monitor[ch] = (sel_ff == 2'(ch)) &&
                                ((state_ff == ST_RUN) || (state_ff == ST_HALT));
   end
   assign pulse_busy_monitor_ch0 = busy_monitor[0];
   assign pulse_busy_monitor_ch1 = busy_monitor[1];
   assign execution_state = (state_ff == ST_RUN);
   assign drive = drive_ff;
endmodule

//--- verilog/vspeed_pkg.sv
// Shared constants and carriers for the variable speed pulse output
package vspeed_pkg;
   localparam int unsigned CLOCK_HZ = 200_000_000;
   localparam int unsigned CH_COUNT = 2;
   // Frequency accumulator: phase step per clock is freq * 2^40 / CLOCK_HZ
   localparam int unsigned PHASE_W = 40;
   localparam logic [7:0] PHASE_SCALE_SHIFT = 8'h28;
   // Ramp step: Hz added per ramp tick, one tick per ramp period
   localparam int unsigned RAMP_TICK_NS = 1000;
   localparam int unsigned RAMP_TICK_CYC = (RAMP_TICK_NS * (CLOCK_HZ / 1_000_000)) / 1000;
   localparam logic [15:0] RAMP_TICK_LAST = 16'(RAMP_TICK_CYC - 1);
   localparam logic [31:0] MAG_ZERO = 32'h0000_0000;
   localparam logic [31:0] MAX_WIDE_HZ = 32'h0003_0D40;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_HALT = 2'b10,
      ST_HELD = 2'b11
   } run_state_e;

   // One command as issued by the user program each scan
   typedef struct packed {
      logic enable;
      logic wide;
      logic [31:0] freq;
      logic [1:0] pulse_output_select;
   } command_s;

   // Pins toward the drive amplifier
   typedef struct packed {
      logic [3:0] pulse;
      logic [3:0] direction;
   } drive_s;
endpackage
